// *** rtl/iprio_bank.sv ***
// Priority register bank: APB slave, seven priority registers, enables and request gating
//
// Implementation choices: the APB register port and the placing of the registers.
`timescale 1ns/100ps
module iprio_bank #(
    parameter int N_SRC = iprio_pkg::NUM_SRC
) (
    input  wire logic                              clock_in,
    input  wire logic                              reset_in,
    input  wire logic                              psel_in,
    input  wire logic                              penable_in,
    input  wire logic                              pwrite_in,
    input  wire logic [iprio_pkg::ADDR_W-1:0]      paddr_in,
    input  wire logic [31:0]                       pwdata_in,
    output logic      [31:0]                       prdata_out,
    output logic                                   pready_out,
    output logic                                   pslverr_out,
    input  wire logic [N_SRC-1:0]                  flag_in,
    output logic      [N_SRC-1:0]                  request_out,
    output iprio_pkg::iprio_levels_t               levels_out
);
    // -------------------------------------------------------------------------
    // Bus decode
    // -------------------------------------------------------------------------
    iprio_pkg::iprio_apb_req_t req;
    logic                      access;
    logic                      in_bank;
    logic [iprio_pkg::ADDR_W-1:0] rel_addr;
    logic [2:0]                reg_idx;
    logic                      hit_en;
    logic                      hit_act;
    logic                      mapped;

    assign req      = '{sel: psel_in, enable: penable_in, write: pwrite_in,
                        addr: paddr_in, wdata: pwdata_in};
    assign access   = req.sel && req.enable;
    assign rel_addr = req.addr - iprio_pkg::PRIO_BASE;
    assign reg_idx  = rel_addr[4:2];
    // Word-aligned only; anything else is unmapped and errors
    assign in_bank  = (req.addr >= iprio_pkg::PRIO_BASE)
                   && (rel_addr[iprio_pkg::ADDR_W-1:2] < iprio_pkg::NUM_REGS)
                   && (req.addr[1:0] == 2'h0);
    assign hit_en   = (req.addr == iprio_pkg::ENABLE_ADDR);
    assign hit_act  = (req.addr == iprio_pkg::ACTIVE_ADDR);
    assign mapped   = in_bank || hit_en || hit_act;

    // Zero-wait slave: answer in the first access cycle
    assign pready_out  = 1'b1;
    assign pslverr_out = access && !mapped;

    // -------------------------------------------------------------------------
    // Priority fields
    // -------------------------------------------------------------------------
    logic [iprio_pkg::LVL_W-1:0] lvl  [iprio_pkg::NUM_REGS*iprio_pkg::SLOTS];
    logic                        live [iprio_pkg::NUM_REGS*iprio_pkg::SLOTS];
    logic [iprio_pkg::LVL_W*N_SRC-1:0] lvl_flat;
    logic [N_SRC-1:0]            live_src;

    // One field per used slot; unused slots are constant zero
    for (genvar g = 0; g < iprio_pkg::NUM_REGS*iprio_pkg::SLOTS; g++) begin : g_slot
        localparam int R = g / iprio_pkg::SLOTS;
        localparam int S = g % iprio_pkg::SLOTS;
        localparam int B = S * iprio_pkg::SLOT_PITCH;
        if (iprio_pkg::SLOT_USED[R][S]) begin : g_used   // [RULE6] [RULE7] [RULE8]
            iprio_field u_field (
                .clock_in  (clock_in),
                .reset_in  (reset_in),
                .wr_in     (access && req.write && in_bank && reg_idx == 3'(R)),
                .data_in   (req.wdata[B +: iprio_pkg::LVL_W]),
                .level_out (lvl[g]),
                .live_out  (live[g])
            );
            // Source order follows the struct: first named source is the top slice
            assign lvl_flat[iprio_pkg::LVL_W*(N_SRC-1-int'(iprio_pkg::SLOT_SRC[g]))
                            +: iprio_pkg::LVL_W] = lvl[g];   // [RULE9] [RULE10]
            assign live_src[N_SRC-1-int'(iprio_pkg::SLOT_SRC[g])] = live[g];
        end else begin : g_unused
            // Writes dropped, reads zero
            assign lvl[g]  = iprio_pkg::LVL_OFF;     // [RULE4]
            assign live[g] = 1'b0;
        end
    end

    // Present every field as a per-source level
    assign levels_out = iprio_pkg::iprio_levels_t'(lvl_flat);   // [RULE14] [RULE11] [RULE12]

    // -------------------------------------------------------------------------
    // Enable bits and request gating
    // -------------------------------------------------------------------------
    logic [N_SRC-1:0] enable_q;
    logic [N_SRC-1:0] enable_d;

    // Software sets or clears enables with a full-word write
    always_comb begin
        enable_d = enable_q;
        if (access && req.write && hit_en) begin
            enable_d = req.wdata[N_SRC-1:0];         // [RULE13]
        end
    end

    // Enables start cleared so nothing requests before software is ready
    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            enable_q <= '0;
        end else begin
            enable_q <= enable_d;
        end
    end

    // Bit i of request follows struct order reversed: bit 0 is uart A receive
    for (genvar i = 0; i < N_SRC; i++) begin : g_src
        iprio_gate u_gate (
            .clock_in    (clock_in),
            .reset_in    (reset_in),
            .flag_in     (flag_in[i]),
            .enable_in   (enable_q[i]),
            .live_in     (live_src[N_SRC-1-i]),
            .request_out (request_out[i])
        );
    end

    // -------------------------------------------------------------------------
    // Read data
    // -------------------------------------------------------------------------
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic [31:0] word;

    // Gather one register; holes stay zero
    always_comb begin
        word = '0;
        for (int s = 0; s < iprio_pkg::SLOTS; s++) begin
            word[s*iprio_pkg::SLOT_PITCH +: iprio_pkg::LVL_W] =
                lvl[int'(reg_idx)*iprio_pkg::SLOTS + s];   // [RULE4]
        end
        rdata_d = rdata_q;
        if (req.sel && !req.enable && !req.write) begin
            // Captured in setup so access-phase data comes from a flop
            if (in_bank) begin
                rdata_d = word;
            end else if (hit_en) begin
                rdata_d = 32'(enable_q);
            end else if (hit_act) begin
                rdata_d = 32'(request_out);
            end else begin
                rdata_d = '0;
            end
        end
    end

    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign prdata_out = rdata_q;

    // -------------------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------------------
    a_write_top_level : assert property (@(posedge clock_in) disable iff (reset_in)
        access && req.write && in_bank && reg_idx == 3'h0 && req.wdata[14:12] == 3'h7
        |=> levels_out.uart_a_receive_level == iprio_pkg::LVL_HIGHEST) // [RULE1]
        else $error("written top level not shown");
    a_lowest_level : assert property (@(posedge clock_in) disable iff (reset_in)
        access && req.write && in_bank && reg_idx == 3'h0 && req.wdata[2:0] == 3'h1
        |=> levels_out.timer_three_level == iprio_pkg::LVL_LOWEST) // [RULE2]
        else $error("level one not shown");
    a_disabled_quiet : assert property (@(posedge clock_in) disable iff (reset_in)
        levels_out.uart_a_receive_level == iprio_pkg::LVL_OFF |=> !request_out[0]) // [RULE3]
        else $error("disabled source requested");
    a_hole_bits_zero : assert property (@(posedge clock_in) disable iff (reset_in)
        access && !req.write && in_bank |-> prdata_out[15] == 1'b0
        && prdata_out[11] == 1'b0 && prdata_out[7] == 1'b0 && prdata_out[3] == 1'b0) // [RULE4]
        else $error("unused bit read nonzero");
    a_reg3_upper : assert property (@(posedge clock_in) disable iff (reset_in)
        access && !req.write && in_bank && $past(reg_idx) == 3'h1 && reg_idx == 3'h1
        |-> prdata_out[15:11] == 5'h0) // [RULE7]
        else $error("register 3 upper bits nonzero");
    a_reg4_middle : assert property (@(posedge clock_in) disable iff (reset_in)
        access && !req.write && in_bank && reg_idx == 3'h2 |-> prdata_out[11:7] == 5'h0) // [RULE8]
        else $error("register 4 middle bits nonzero");
    a_enable_pass : assert property (@(posedge clock_in) disable iff (reset_in)
        enable_q[5] && flag_in[5] && levels_out.adc_a_done_level != 3'h0
        |=> request_out[5]) // [RULE13]
        else $error("enabled flagged source not requesting");
    a_reg8_slot : assert property (@(posedge clock_in) disable iff (reset_in)
        access && req.write && in_bank && reg_idx == 3'h6
        |=> levels_out.spi_b_error_level == $past(req.wdata[2:0])) // [RULE12]
        else $error("spi B error field mismatch");
    // One slot per register checked end to end: bus bit position to named output
    a_reg2_slot : assert property (@(posedge clock_in) disable iff (reset_in)
        access && req.write && in_bank && reg_idx == 3'h0
        |=> levels_out.spi_a_error_level == $past(req.wdata[6:4])) // [RULE6]
        else $error("spi A error field mismatch");
    a_reg3_slot : assert property (@(posedge clock_in) disable iff (reset_in)
        access && req.write && in_bank && reg_idx == 3'h1
        |=> levels_out.dma_ch_one_level == $past(req.wdata[10:8])) // [RULE7]
        else $error("dma one field mismatch");
    a_reg4_slot : assert property (@(posedge clock_in) disable iff (reset_in)
        access && req.write && in_bank && reg_idx == 3'h2
        |=> levels_out.pin_change_level == $past(req.wdata[14:12])) // [RULE8]
        else $error("pin change field mismatch");
    a_reg5_slot : assert property (@(posedge clock_in) disable iff (reset_in)
        access && req.write && in_bank && reg_idx == 3'h3
        |=> levels_out.capture_eight_level == $past(req.wdata[14:12])) // [RULE9]
        else $error("capture eight field mismatch");
    a_reg6_slot : assert property (@(posedge clock_in) disable iff (reset_in)
        access && req.write && in_bank && reg_idx == 3'h4
        |=> levels_out.dma_ch_two_level == $past(req.wdata[2:0])) // [RULE10]
        else $error("dma two field mismatch");
    a_reg7_slot : assert property (@(posedge clock_in) disable iff (reset_in)
        access && req.write && in_bank && reg_idx == 3'h5
        |=> levels_out.ext_irq_two_level == $past(req.wdata[6:4])) // [RULE11]
        else $error("external irq two field mismatch");
    // Read path and level outputs must agree, or arbitration sees another value
    a_level_mirror : assert property (@(posedge clock_in) disable iff (reset_in)
        access && !req.write && in_bank && reg_idx == 3'h0
        |-> prdata_out[14:12] == levels_out.uart_a_receive_level) // [RULE14]
        else $error("read data and level output differ");
    c_write_bank : cover property (@(posedge clock_in) access && req.write && in_bank);
    c_read_bank : cover property (@(posedge clock_in) access && !req.write && in_bank);
    c_unmapped : cover property (@(posedge clock_in) pslverr_out);
    c_request : cover property (@(posedge clock_in) request_out != '0);
endmodule : iprio_bank

// *** common/iprio_pkg.sv ***
// Package: register map, field layout, reset values and carrier types for the priority bank
// -----------------------------------------------------------------------------
// Functional notes
// [RULE1] Each source has a 3-bit writable priority; 111 means level 7, the highest.
// [RULE2] Code 001 is level 1, the lowest enabled; other codes equal their level.
// [RULE3] Code 000 disables the source; it never requests, whatever its flag or enable.
// [RULE4] Bits without a field ignore writes and read as zero.
// [RULE5] After reset each field is 100, level 4.
// [RULE6] Register 2: uart A receive, spi A event, spi A error, timer three.
// [RULE7] Register 3: bits 15-11 unused; dma one, adc A done, uart A transmit.
// [RULE8] Register 4: pin change at 14-12, bits 11-7 unused, i2c A master, i2c A slave.
// [RULE9] Register 5: capture eight, capture seven, adc B done, external irq one.
// [RULE10] Register 6: timer four, compare four, compare three, dma two.
// [RULE11] Register 7: uart B transmit, uart B receive, external irq two, timer five.
// [RULE12] Register 8: can A event, can A receive, spi B event, spi B error.
// [RULE13] Each source also has an enable bit; one permits requests, zero blocks them.
// [RULE14] Each field's value is presented as a 3-bit priority output per source.
// -----------------------------------------------------------------------------
package iprio_pkg;

    // -------------------------------------------------------------------------
    // Sizes
    // -------------------------------------------------------------------------
    localparam int NUM_REGS   = 7;
    localparam int SLOTS      = 4;
    localparam int NUM_SRC    = 26;
    localparam int LVL_W      = 3;
    localparam int REG_W      = 16;
    localparam int SLOT_PITCH = 4;
    localparam int ADDR_W     = 12;

    // -------------------------------------------------------------------------
    // Byte offsets (index times four); enable register placed after the bank
    // -------------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] PRIO_BASE   = 12'h008;
    localparam logic [ADDR_W-1:0] ENABLE_ADDR = 12'h040;
    localparam logic [ADDR_W-1:0] ACTIVE_ADDR = 12'h044;

    // Reset value of one field: top bit one, lower bits zero
    localparam logic [LVL_W-1:0] LVL_RESET   = 3'h4;
    localparam logic [LVL_W-1:0] LVL_OFF     = 3'h0;
    localparam logic [LVL_W-1:0] LVL_HIGHEST = 3'h7;
    localparam logic [LVL_W-1:0] LVL_LOWEST  = 3'h1;

    // Which of the four slots hold a field, per register (slot 3 is bits 14-12)
    localparam logic [SLOTS-1:0] SLOT_USED [NUM_REGS] = '{
        4'hf, 4'h7, 4'hb, 4'hf, 4'hf, 4'hf, 4'hf};

    // Source number of each slot, flat index reg*4+slot; unused slots hold zero
    localparam logic [4:0] SLOT_SRC [NUM_REGS*SLOTS] = '{
        5'h03, 5'h02, 5'h01, 5'h00,
        5'h06, 5'h05, 5'h04, 5'h00,
        5'h09, 5'h08, 5'h00, 5'h07,
        5'h0d, 5'h0c, 5'h0b, 5'h0a,
        5'h11, 5'h10, 5'h0f, 5'h0e,
        5'h15, 5'h14, 5'h13, 5'h12,
        5'h19, 5'h18, 5'h17, 5'h16};

    // APB request as seen by the slave
    typedef struct packed {
        logic              sel;
        logic              enable;
        logic              write;
        logic [ADDR_W-1:0] addr;
        logic [31:0]       wdata;
    } iprio_apb_req_t;

    // Per-source priority outputs grouped by name
    typedef struct packed {
        logic [LVL_W-1:0] uart_a_receive_level;
        logic [LVL_W-1:0] spi_a_event_level;
        logic [LVL_W-1:0] spi_a_error_level;
        logic [LVL_W-1:0] timer_three_level;
        logic [LVL_W-1:0] dma_ch_one_level;
        logic [LVL_W-1:0] adc_a_done_level;
        logic [LVL_W-1:0] uart_a_transmit_level;
        logic [LVL_W-1:0] pin_change_level;
        logic [LVL_W-1:0] i2c_a_master_level;
        logic [LVL_W-1:0] i2c_a_slave_level;
        logic [LVL_W-1:0] capture_eight_level;
        logic [LVL_W-1:0] capture_seven_level;
        logic [LVL_W-1:0] adc_b_done_level;
        logic [LVL_W-1:0] ext_irq_one_level;
        logic [LVL_W-1:0] timer_four_level;
        logic [LVL_W-1:0] compare_four_level;
        logic [LVL_W-1:0] compare_three_level;
        logic [LVL_W-1:0] dma_ch_two_level;
        logic [LVL_W-1:0] uart_b_transmit_level;
        logic [LVL_W-1:0] uart_b_receive_level;
        logic [LVL_W-1:0] ext_irq_two_level;
        logic [LVL_W-1:0] timer_five_level;
        logic [LVL_W-1:0] can_a_event_level;
        logic [LVL_W-1:0] can_a_receive_level;
        logic [LVL_W-1:0] spi_b_event_level;
        logic [LVL_W-1:0] spi_b_error_level;
    } iprio_levels_t;

endpackage : iprio_pkg

// *** rtl/iprio_field.sv ***
// One 3-bit priority field with write strobe and level decode
`timescale 1ns/100ps
module iprio_field (
    input  wire logic                      clock_in,
    input  wire logic                      reset_in,
    input  wire logic                      wr_in,
    input  wire logic [iprio_pkg::LVL_W-1:0] data_in,
    output logic      [iprio_pkg::LVL_W-1:0] level_out,
    output logic                           live_out
);
    logic [iprio_pkg::LVL_W-1:0] lvl_q;
    logic [iprio_pkg::LVL_W-1:0] lvl_d;

    // Next value: take bus data on a write
    always_comb begin
        lvl_d = wr_in ? data_in : lvl_q;               // [RULE1]
    end

    // Field storage, default level four
    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            lvl_q <= iprio_pkg::LVL_RESET;             // [RULE5]
        end else begin
            lvl_q <= lvl_d;
        end
    end

    // Code equals level; zero means the source is shut off
    assign level_out = lvl_q;                          // [RULE2]
    assign live_out  = (lvl_q != iprio_pkg::LVL_OFF);  // [RULE3]

    a_reset_level : assert property (@(posedge clock_in)
        $fell(reset_in) |-> lvl_q == iprio_pkg::LVL_RESET) // [RULE5]
        else $error("field not at level four after reset");
endmodule : iprio_field

// *** rtl/iprio_gate.sv ***
// Request gate: enable bit and nonzero level both needed
`timescale 1ns/100ps
module iprio_gate (
    input  wire logic clock_in,
    input  wire logic reset_in,
    input  wire logic flag_in,
    input  wire logic enable_in,
    input  wire logic live_in,
    output logic      request_out
);
    logic req_q;
    logic req_d;

    // Level zero blocks even an enabled, flagged source
    always_comb begin
        req_d = flag_in && enable_in && live_in;       // [RULE3] [RULE13]
    end

    // Registered so the request output comes from a flip-flop
    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            req_q <= 1'b0;
        end else begin
            req_q <= req_d;
        end
    end

    assign request_out = req_q;

    a_gate_block : assert property (@(posedge clock_in) disable iff (reset_in)
        !(enable_in && live_in) |=> !request_out)      // [RULE13]
        else $error("request passed a closed gate");
endmodule : iprio_gate

// *** testbench/iprio_bank_tb_top.sv ***
// Self-checking bench for the priority register bank
`timescale 1ns/100ps
module iprio_bank_tb_top;
    // ---------------------------------------------------------------
    // Signals, tables and design instance
    // ---------------------------------------------------------------
    logic                     clock_in;
    logic                     reset_in;
    logic                     psel;
    logic                     penable;
    logic                     pwrite;
    logic [11:0]              paddr;
    logic [31:0]              pwdata;
    logic [31:0]              prdata;
    logic                     pready;
    logic                     pslverr;
    logic [25:0]              flag;
    logic [25:0]              request;
    iprio_pkg::iprio_levels_t levels;
    logic [77:0]              lv_flat;
    logic [15:0]              exp_reg [7];
    int                       error_cnt;
    int                       checked;
    int                       cycles;
    // Owning register and low bit of each source, struct order
    int src_reg [26] = '{0,0,0,0,1,1,1,2,2,2,3,3,3,3,4,4,4,4,5,5,5,5,6,6,6,6};
    int src_lsb [26] = '{12,8,4,0,8,4,0,12,4,0,12,8,4,0,12,8,4,0,12,8,4,0,12,8,4,0};
    logic [15:0] used_mask [7] = '{16'h7777, 16'h0777, 16'h7077, 16'h7777,
                                   16'h7777, 16'h7777, 16'h7777};

    assign lv_flat = levels;

    iprio_bank i_dut (
        .clock_in    (clock_in),
        .reset_in    (reset_in),
        .psel_in     (psel),
        .penable_in  (penable),
        .pwrite_in   (pwrite),
        .paddr_in    (paddr),
        .pwdata_in   (pwdata),
        .prdata_out  (prdata),
        .pready_out  (pready),
        .pslverr_out (pslverr),
        .flag_in     (flag),
        .request_out (request),
        .levels_out  (levels)
    );

    // ---------------------------------------------------------------
    // Shared helpers
    // ---------------------------------------------------------------
    function automatic logic [31:0] lv(input int s);
        return {29'h0, lv_flat[(25-s)*3 +: 3]};
    endfunction : lv

    function automatic logic [11:0] reg_addr(input int r);
        return iprio_pkg::PRIO_BASE + 12'(r * 4);
    endfunction : reg_addr

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // One APB transfer; request held until pready is seen high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        @(posedge clock_in);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge clock_in);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock_in);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) chk("pready wait", 32'h1, 32'h0);
    endtask : apb

    task automatic test_done();
        $display("Comparisons %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : test_done

    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    task automatic test_reset();
        logic [31:0] rd;
        logic        err;
        for (int r = 0; r < 7; r++) begin
            apb(1'b0, reg_addr(r), 32'h0, rd, err);
            chk("reset value", {16'h0, used_mask[r] & 16'h4444}, rd);
        end
        for (int s = 0; s < 26; s++) chk("reset level", 32'h4, lv(s));
        chk("request idle", 32'h0, {6'h0, request});
        $display("test_reset done");
    endtask : test_reset

    // All ones written: only field bits stick, unused bits read zero
    task automatic test_all_ones();
        logic [31:0] rd;
        logic        err;
        for (int r = 0; r < 7; r++) begin
            apb(1'b1, reg_addr(r), 32'hffffffff, rd, err);
            apb(1'b0, reg_addr(r), 32'h0, rd, err);
            chk("unused bits", {16'h0, used_mask[r]}, rd);
        end
        @(negedge clock_in);
        for (int s = 0; s < 26; s++) chk("top level", 32'h7, lv(s));
        $display("test_all_ones done");
    endtask : test_all_ones

    // Code of source number mod 8 per source checks each field lands on its own output
    task automatic test_field_map();
        logic [31:0] rd;
        logic        err;
        for (int r = 0; r < 7; r++) exp_reg[r] = 16'h0;
        for (int s = 0; s < 26; s++) exp_reg[src_reg[s]][src_lsb[s] +: 3] = 3'(s % 8);
        for (int r = 0; r < 7; r++) apb(1'b1, reg_addr(r), {16'h0, exp_reg[r]}, rd, err);
        for (int r = 0; r < 7; r++) begin
            apb(1'b0, reg_addr(r), 32'h0, rd, err);
            chk("field readback", {16'h0, exp_reg[r]}, rd);
        end
        @(negedge clock_in);
        for (int s = 0; s < 26; s++) chk("field level", 32'(s % 8), lv(s));
        $display("test_field_map done");
    endtask : test_field_map

    // Sources at code zero stay silent even when flagged and enabled
    task automatic test_gating();
        logic [31:0] rd;
        logic        err;
        logic [25:0] exp;
        for (int s = 0; s < 26; s++) exp[s] = (s % 8) != 0;
        @(posedge clock_in);
        flag <= 26'h3ffffff;
        apb(1'b1, iprio_pkg::ENABLE_ADDR, 32'h03ffffff, rd, err);
        repeat (2) @(posedge clock_in);
        @(negedge clock_in);
        chk("request gated", {6'h0, exp}, {6'h0, request});
        apb(1'b0, iprio_pkg::ACTIVE_ADDR, 32'h0, rd, err);
        chk("active read", {6'h0, exp}, rd);
        apb(1'b1, iprio_pkg::ENABLE_ADDR, 32'h0, rd, err);
        repeat (2) @(posedge clock_in);
        @(negedge clock_in);
        chk("request disabled", 32'h0, {6'h0, request});
        $display("test_gating done");
    endtask : test_gating

    // Unmapped places refused, then a reset in mid-run
    task automatic test_refused();
        logic [31:0] rd;
        logic        err;
        apb(1'b1, 12'h100, 32'hffffffff, rd, err);
        chk("unmapped write err", 32'h1, {31'h0, err});
        apb(1'b0, 12'h004, 32'h0, rd, err);
        chk("unmapped read err", 32'h1, {31'h0, err});
        chk("unmapped read data", 32'h0, rd);
        apb(1'b0, reg_addr(0), 32'h0, rd, err);
        chk("reg kept", {16'h0, exp_reg[0]}, rd);
        chk("mapped read err", 32'h0, {31'h0, err});
        @(posedge clock_in);
        reset_in <= 1'b1;
        @(negedge clock_in);
        for (int s = 0; s < 26; s++) chk("mid reset level", 32'h4, lv(s));
        @(posedge clock_in);
        reset_in <= 1'b0;
        // Flags still high, but enables were already cleared in test_gating, so no request is expected here
        apb(1'b0, iprio_pkg::ENABLE_ADDR, 32'h0, rd, err);
        chk("enable after reset", 32'h0, rd);
        chk("request after reset", 32'h0, {6'h0, request});
        $display("test_refused done");
    endtask : test_refused

    // ---------------------------------------------------------------
    // Clock, timeout and main sequence
    // ---------------------------------------------------------------
    initial begin
        clock_in = 1'b0;
        forever #2 clock_in = ~clock_in;
    end

    // Whole run needs well under a thousand cycles
    always @(posedge clock_in) begin
        cycles <= cycles + 1;
        if (cycles >= 5000) begin
            error_cnt++;
            test_done();
        end
    end

    initial begin
        error_cnt = 0;
        checked   = 0;
        cycles    = 0;
        reset_in  = 1'b1;
        psel      = 1'b0;
        penable   = 1'b0;
        pwrite    = 1'b0;
        paddr     = 12'h000;
        pwdata    = 32'h0;
        flag      = 26'h0;
        repeat (4) @(posedge clock_in);
        reset_in <= 1'b0;
        test_reset();
        test_all_ones();
        test_field_map();
        test_gating();
        test_refused();
        test_done();
    end
endmodule : iprio_bank_tb_top
